/* logic/scp_pkg.sv */
// Constants for the system-control pipeline timing block.
// Assumes a single clock domain; all users import scp_pkg::*.
// Notes on behaviour
// - Pre-decrement control store: five stages, pointer written back
// - Control load/store memory access arbitrated against fetch
// - Post-increment control load stalls dependent reader
// - DSP variant: decode after control load held four
// - DSP variant: decode after control store held one
// - Bounds and loop registers exist only on DSP
// - Banked store: six stages, decode stalled one
// - Banked store memory access arbitrated with fetch
// - Moves into accumulator: four stages, multiplier access
// - Multiplier user after DSP transfer is stalled
// - Memory loads into accumulator: four stages, contend
// - Accumulator to register: five stages, hazard stall
// - Exception return: three execute, one delay slot
// - Exception return discards second, target after execute
// - Software trap: four execute, not delayed branch
// - Trap discards two fetched, target after execute
// - DSP variant trap runs six execute stages
package scp_pkg;
   // Instruction classes as decoded upstream
   localparam logic [3:0] CLS_PLAIN = 4'h0;
   localparam logic [3:0] CLS_CTRL_STORE = 4'h1; // control_reg_store_mem, non-banked
   localparam logic [3:0] CLS_CTRL_LOAD = 4'h2; // control_reg_load_mem
   localparam logic [3:0] CLS_BANK_STORE = 4'h3; // alternate_bank_gpr store
   localparam logic [3:0] CLS_MAC_MOVE_IN = 4'h4; // sys_reg_move_in, accum_clear
   localparam logic [3:0] CLS_MAC_LOAD = 4'h5; // sys_reg_load_mem
   localparam logic [3:0] CLS_MAC_MOVE_OUT = 4'h6; // sys_reg_move_out
   localparam logic [3:0] CLS_MAC_STORE = 4'h7; // sys_reg_store_mem
   localparam logic [3:0] CLS_EXC_RETURN = 4'h8; // exception_return
   localparam logic [3:0] CLS_TRAP = 4'h9; // software_trap
   localparam logic [3:0] CLS_MUL_USER = 4'ha; // any multiplier user
   // Execute-stage counts per class
   localparam logic [2:0] EX_ONE = 3'h1;
   localparam logic [2:0] EX_BANK = 3'h2;
   localparam logic [2:0] EX_RETURN = 3'h3;
   localparam logic [2:0] EX_TRAP = 3'h4;
   localparam logic [2:0] EX_TRAP_DSP = 3'h6;
   // Decode hold-off and fetch-discard slot counts; control load/store hold-offs on the DSP variant only
   localparam logic [2:0] HOLD_LOAD_DSP = 3'h4;
   localparam logic [2:0] HOLD_STORE_DSP = 3'h1;
   localparam logic [2:0] HOLD_BANK = 3'h1;
   localparam logic [2:0] HOLD_NONE = 3'h0;
   localparam logic [2:0] DISCARD_RETURN = 3'h1;
   localparam logic [2:0] DISCARD_TRAP = 3'h2;
   // Control register selectors reserved to the DSP variant
   localparam logic [3:0] CREG_BOUNDS = 4'h4; // circular_buffer_bounds
   localparam logic [3:0] CREG_LOOP_FIRST = 4'h5; // loop_first_pc
   localparam logic [3:0] CREG_LOOP_LAST = 4'h6; // loop_last_pc
   localparam logic [3:0] GPR_NONE = 4'h0;
endpackage : scp_pkg

/* logic/scp_stage_if.sv */
// Carries one instruction slot between pipeline stages.
// Assumes the stage registers and the hazard logic share mclk.
`timescale 1ns/100ps
interface scp_stage_if;
   logic valid;
   logic [3:0] cls;
   logic [3:0] dst;
   logic memUse;
   logic mulUse;
   modport src (output valid, output cls, output dst, output memUse, output mulUse);
   modport snk (input valid, input cls, input dst, input memUse, input mulUse);
endinterface : scp_stage_if

/* logic/scp_stage_reg.sv */
// One pipeline stage register; holds when told, bubbles when flushed.
// Assumes the hazard logic drives hold and flush in the same cycle.
`timescale 1ns/100ps
module scp_stage_reg
   import scp_pkg::*;
(
   input wire logic mclk, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic hold, // Keep current contents
   input wire logic bubble, // Load an empty slot
   scp_stage_if.snk din, // Younger side
   scp_stage_if.src dout // Older side
);
   logic next_valid;
   logic [3:0] next_cls;
   logic [3:0] next_dst;
   logic next_memUse;
   logic next_mulUse;

   // Hold keeps the slot in place; bubble empties it
   always_comb begin
      next_valid = dout.valid;
      next_cls = dout.cls;
      next_dst = dout.dst;
      next_memUse = dout.memUse;
      next_mulUse = dout.mulUse;
      if (!hold) begin
         next_valid = din.valid & ~bubble;
         next_cls = din.cls;
         next_dst = din.dst;
         next_memUse = din.memUse & ~bubble;
         next_mulUse = din.mulUse & ~bubble;
      end
   end

   // Registers only
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dout.valid <= 1'b0;
         dout.cls <= CLS_PLAIN;
         dout.dst <= GPR_NONE;
         dout.memUse <= 1'b0;
         dout.mulUse <= 1'b0;
      end else begin
         dout.valid <= next_valid;
         dout.cls <= next_cls;
         dout.dst <= next_dst;
         dout.memUse <= next_memUse;
         dout.mulUse <= next_mulUse;
      end
   end
endmodule : scp_stage_reg

/* logic/scp_pipe_ctrl.sv */
// Stage sequencing and hazard control for system-control instructions.
// Assumes a decoder classifies the instruction in decode and that the
// fetch unit honours fetchGrant, flush and redirect.
`timescale 1ns/100ps
module scp_pipe_ctrl
   import scp_pkg::*;
#(
   parameter bit DSP_VARIANT = 1'b0 // DSP-extended variant
) (
   input wire logic mclk, // System clock, 10 MHz
   input wire logic nrst, // Async reset, active low
   input wire logic decValid, // Instruction present in decode
   input wire logic [3:0] decCls, // Its class
   input wire logic [3:0] decCreg, // Control register selected
   input wire logic [3:0] decDst, // Destination register, 0 none
   input wire logic [3:0] decSrcA, // Source register read
   input wire logic [3:0] decSrcB, // Second source register read
   input wire logic fetchReq, // Fetch unit wants the bus
   output logic decStall, // Decode held this slot
   output logic fetchGrant, // Fetch may use the bus
   output logic memGrant, // Memory access owns the bus
   output logic mulAccess, // Memory stage drives multiplier
   output logic ptrWrite, // Write-back of updated pointer
   output logic regWrite, // Write-back of loaded register
   output logic [3:0] wbDst, // Register written back
   output logic fetchDiscard, // Fetched slot is thrown away
   output logic redirect, // Start fetch of branch target
   output logic illegalOp // Control register absent on this variant
);
   // -----------------------------------------------------------------
   // Stage registers
   // -----------------------------------------------------------------
   scp_stage_if exIn ();
   scp_stage_if exOut ();
   scp_stage_if maOut ();
   scp_stage_if wbOut ();

   logic exHold;
   logic maHold;
   logic exBubble;
   logic illegalNow;
   logic hazard;
   logic [2:0] exLeft;
   logic [2:0] holdLeft;
   logic [2:0] discLeft;
   logic [2:0] next_exLeft;
   logic [2:0] next_holdLeft;
   logic [2:0] next_discLeft;
   logic redirPend;
   logic next_redirPend;
   logic mulLast;
   logic next_mulLast;

   // Bounds and loop registers are undefined on the base variants
   assign illegalNow = decValid && !DSP_VARIANT &&
      (decCls == CLS_CTRL_LOAD || decCls == CLS_CTRL_STORE) &&
      (decCreg == CREG_BOUNDS || decCreg == CREG_LOOP_FIRST || decCreg == CREG_LOOP_LAST);

   // Decode slot fields
   assign exIn.valid = decValid & ~illegalNow;
   assign exIn.cls = decCls;
   assign exIn.dst = decDst;
   assign exIn.memUse = decCls inside {CLS_CTRL_STORE, CLS_CTRL_LOAD, CLS_BANK_STORE,
      CLS_MAC_MOVE_IN, CLS_MAC_LOAD, CLS_MAC_MOVE_OUT, CLS_MAC_STORE};
   assign exIn.mulUse = decCls inside {CLS_MAC_MOVE_IN, CLS_MAC_LOAD, CLS_MAC_MOVE_OUT,
      CLS_MAC_STORE, CLS_MUL_USER};

   // Load-use and multiplier hazards against the instruction ahead
   assign hazard = decValid && exOut.valid &&
      (((exOut.cls == CLS_CTRL_LOAD || exOut.cls == CLS_MAC_MOVE_OUT) &&
        exOut.dst != GPR_NONE && (decSrcA == exOut.dst || decSrcB == exOut.dst)) ||
       (mulLast && exIn.mulUse));

   // Multi-cycle execute keeps the slot; memory stage waits for the bus
   assign maHold = maOut.valid && maOut.memUse && !memGrant;
   assign exHold = maHold || (exLeft > EX_ONE);
   assign exBubble = hazard || (holdLeft != HOLD_NONE) || redirPend;

   // Younger stages hold while older ones drain
   scp_stage_reg uEx (.mclk(mclk), .nrst(nrst), .hold(exHold),
      .bubble(exBubble), .din(exIn), .dout(exOut));
   scp_stage_reg uMa (.mclk(mclk), .nrst(nrst), .hold(maHold),
      .bubble(exLeft > EX_ONE), .din(exOut), .dout(maOut));
   scp_stage_reg uWb (.mclk(mclk), .nrst(nrst), .hold(1'b0),
      .bubble(maHold), .din(maOut), .dout(wbOut));

   // -----------------------------------------------------------------
   // Execute counting, decode hold-off and discard sequencing
   // -----------------------------------------------------------------
   always_comb begin
      next_exLeft = exLeft;
      next_holdLeft = holdLeft;
      next_discLeft = discLeft;
      next_redirPend = 1'b0;
      next_mulLast = mulLast;
      if (holdLeft != HOLD_NONE) begin
         next_holdLeft = holdLeft - 3'h1;
      end
      if (exLeft > EX_ONE) begin
         next_exLeft = exLeft - 3'h1;
         // Target fetch in the slot after the last execute
         next_redirPend = (exLeft == 3'h2) &&
            (exOut.cls == CLS_EXC_RETURN || exOut.cls == CLS_TRAP);
      end else if (!exHold && exIn.valid && !exBubble) begin
         next_mulLast = exIn.mulUse && exIn.cls != CLS_MUL_USER;
         case (exIn.cls)
            CLS_BANK_STORE: begin
               next_exLeft = EX_BANK;
               next_holdLeft = HOLD_BANK;
            end
            CLS_CTRL_LOAD: begin
               next_exLeft = EX_ONE;
               next_holdLeft = DSP_VARIANT ? HOLD_LOAD_DSP : HOLD_NONE;
            end
            CLS_CTRL_STORE: begin
               next_exLeft = EX_ONE;
               next_holdLeft = DSP_VARIANT ? HOLD_STORE_DSP : HOLD_NONE;
            end
            CLS_EXC_RETURN: begin
               next_exLeft = EX_RETURN;
               next_discLeft = DISCARD_RETURN;
            end
            CLS_TRAP: begin
               next_exLeft = DSP_VARIANT ? EX_TRAP_DSP : EX_TRAP;
               next_discLeft = DISCARD_TRAP;
            end
            default: begin
               next_exLeft = EX_ONE;
            end
         endcase
      end else if (!exHold) begin
         next_exLeft = EX_ONE;
         // A bubble or idle slot separates transfers, so no stale contention
         next_mulLast = 1'b0;
      end
      // Exception return lets its delay slot run; trap kills both fetched
      // One fetched slot is thrown away per execute slot until the count ends
      if (discLeft != HOLD_NONE && exLeft > EX_ONE) begin
         next_discLeft = discLeft - 3'h1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         exLeft <= EX_ONE;
         holdLeft <= HOLD_NONE;
         discLeft <= HOLD_NONE;
         redirPend <= 1'b0;
         mulLast <= 1'b0;
      end else begin
         exLeft <= next_exLeft;
         holdLeft <= next_holdLeft;
         discLeft <= next_discLeft;
         redirPend <= next_redirPend;
         mulLast <= next_mulLast;
      end
   end

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   logic next_decStall;
   logic next_fetchGrant;
   logic next_memGrant;
   logic next_mulAccess;
   logic next_ptrWrite;
   logic next_regWrite;
   logic [3:0] next_wbDst;
   logic next_fetchDiscard;
   logic next_illegalOp;

   // Memory access wins the shared bus; fetch is the one delayed
   always_comb begin
      next_memGrant = exOut.valid && exOut.memUse && !(exLeft > EX_ONE);
      next_fetchGrant = fetchReq && !next_memGrant;
      next_mulAccess = next_memGrant && exOut.mulUse;
      next_decStall = decValid && (exHold || exBubble);
      next_ptrWrite = maOut.valid && !maHold &&
         (maOut.cls == CLS_CTRL_STORE || maOut.cls == CLS_BANK_STORE ||
          maOut.cls == CLS_MAC_STORE);
      next_regWrite = maOut.valid && !maHold &&
         (maOut.cls == CLS_CTRL_LOAD || maOut.cls == CLS_MAC_MOVE_OUT);
      next_wbDst = maOut.dst;
      next_fetchDiscard = (discLeft != HOLD_NONE) && (exLeft > EX_ONE) &&
         (exOut.cls == CLS_TRAP || exOut.cls == CLS_EXC_RETURN);
      next_illegalOp = illegalNow;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         decStall <= 1'b0;
         fetchGrant <= 1'b0;
         memGrant <= 1'b0;
         mulAccess <= 1'b0;
         ptrWrite <= 1'b0;
         regWrite <= 1'b0;
         wbDst <= GPR_NONE;
         fetchDiscard <= 1'b0;
         redirect <= 1'b0;
         illegalOp <= 1'b0;
      end else begin
         decStall <= next_decStall;
         fetchGrant <= next_fetchGrant;
         memGrant <= next_memGrant;
         mulAccess <= next_mulAccess;
         ptrWrite <= next_ptrWrite;
         regWrite <= next_regWrite;
         wbDst <= next_wbDst;
         fetchDiscard <= next_fetchDiscard;
         redirect <= redirPend;
         illegalOp <= next_illegalOp;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence trapEnter;
      !exHold && exIn.valid && !exBubble && exIn.cls == CLS_TRAP && exLeft <= EX_ONE;
   endsequence

   chk_bus_exclusive: assert property (!(memGrant && fetchGrant))
      else $error("fetch and memory access granted together");
   chk_bank_fetch: assert property (next_memGrant |=> !fetchGrant)
      else $error("fetch not delayed behind memory access");
   chk_base_illegal: assert property (illegalNow && !exHold |=> illegalOp && !exOut.valid)
      else $error("DSP-only register accepted on base variant");
   chk_trap_length: assert property (trapEnter |=> exLeft == (DSP_VARIANT ? 3'h6 : 3'h4))
      else $error("trap execute length wrong");
   chk_trap_redirect: assert property (trapEnter |=> ##[1:6] redirPend ##1 redirect)
      else $error("trap target fetch missing");
   chk_load_hold: assert property (!exHold && exIn.valid && !exBubble &&
      exIn.cls == CLS_CTRL_LOAD && exLeft <= EX_ONE |=>
      holdLeft == (DSP_VARIANT ? 3'h4 : 3'h0))
      else $error("decode hold after control load wrong");
   chk_bank_stall: assert property (!exHold && exIn.valid && !exBubble &&
      exIn.cls == CLS_BANK_STORE && exLeft <= EX_ONE |=> exLeft == 3'h2 && holdLeft == 3'h1)
      else $error("banked store sequencing wrong");
   chk_hazard_bubble: assert property (hazard && !exHold |=> !exOut.valid)
      else $error("dependent reader not stalled");
   chk_mul_stall: assert property (mulLast && decValid && exOut.valid && exIn.mulUse &&
      !exHold |=> !exOut.valid)
      else $error("multiplier user not stalled");
   chk_hold_older: assert property (exLeft > EX_ONE |=> !$stable(exLeft) || exHold)
      else $error("execute counter stuck");
endmodule : scp_pipe_ctrl

/* dv/scp_fetch_model.sv */
// Model of the shared fetch and data bus as seen by the fetch unit.
// Assumes one clock; the request is changed only just after a rising edge.
`timescale 1ns/100ps
module scp_fetch_model (
   input wire logic mclk, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic fetchGrant, // Fetch owns the bus this slot
   input wire logic memGrant, // Memory access owns the bus this slot
   input wire logic slow, // Leave a gap after each fetch
   output logic fetchReq, // Fetch wants the bus
   output int conflicts, // Slots where both sides owned the bus
   output int starved // Fetches left waiting too long
);
   // ---------------------------------------------------------------
   // Request generation and bus ownership checks
   // ---------------------------------------------------------------
   int waitCnt;
   // Request held until granted; slow mode idles one slot between fetches
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         fetchReq <= 1'b0;
         conflicts <= 0;
         starved <= 0;
         waitCnt <= 0;
      end else begin
         if (fetchReq && fetchGrant === 1'b1) begin
            fetchReq <= !slow;
            waitCnt <= 0;
         end else if (!fetchReq) begin
            fetchReq <= 1'b1;
         end else begin
            waitCnt <= waitCnt + 1;
         end
         // One owner per slot: memory access must push fetch aside
         if (memGrant === 1'b1 && fetchGrant === 1'b1) conflicts <= conflicts + 1;
         // A delayed fetch must still get the bus; long hold-offs are a hang
         if (waitCnt == 20) starved <= starved + 1;
      end
   end
endmodule : scp_fetch_model

/* dv/system_ctrl_pipeline_timing_tb_top.sv */
// Self-checking bench: base and DSP variants run side by side on one stimulus.
// Assumes scp_pkg, the stage interface and the design modules are compiled first.
`timescale 1ns/100ps
module system_ctrl_pipeline_timing_tb_top;
   import scp_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus, observation and counters
   // ---------------------------------------------------------------
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic decValid = 1'b0;
   logic [3:0] decCls = CLS_PLAIN;
   logic [3:0] decCreg = 4'h0;
   logic [3:0] decDst = GPR_NONE;
   logic [3:0] decSrcA = 4'h0;
   logic [3:0] decSrcB = 4'h0;
   logic [3:0] srcB = 4'h0;
   logic reqLast = 1'b0;
   logic slow = 1'b0;
   logic fetchReq;
   logic [1:0] decStall, fetchGrant, memGrant, mulAccess, ptrWrite, regWrite;
   logic [1:0] fetchDiscard, redirect, illegalOp;
   logic [3:0] wbDst [2];
   logic [3:0] lastDst [2];
   int bad_count = 0;
   int checked = 0;
   int conflicts, starved, cyc, nDelay, tLat;
   int nStall[2], nMem[2], nMul[2], nPtr[2], nReg[2], nDisc[2], nRed[2], nIll[2], lat[2];
   bit mon = 1'b0;
   always #50 mclk = ~mclk; // 10 MHz
   // Index 0 is the base variant, index 1 the DSP-extended one
   for (genvar v = 0; v < 2; v++) begin : g_var
      scp_pipe_ctrl #(.DSP_VARIANT(v == 1)) dut_u (
         .mclk(mclk), .nrst(nrst), .decValid(decValid), .decCls(decCls),
         .decCreg(decCreg), .decDst(decDst), .decSrcA(decSrcA), .decSrcB(decSrcB),
         .fetchReq(fetchReq), .decStall(decStall[v]), .fetchGrant(fetchGrant[v]),
         .memGrant(memGrant[v]), .mulAccess(mulAccess[v]), .ptrWrite(ptrWrite[v]),
         .regWrite(regWrite[v]), .wbDst(wbDst[v]), .fetchDiscard(fetchDiscard[v]),
         .redirect(redirect[v]), .illegalOp(illegalOp[v]));
   end
   // Fetch partner follows the base variant's grants
   scp_fetch_model fetch_u (.mclk(mclk), .nrst(nrst), .fetchGrant(fetchGrant[0]),
      .memGrant(memGrant[0]), .slow(slow), .fetchReq(fetchReq), .conflicts(conflicts),
      .starved(starved));
   // Per-run tallies; cleared whenever no run is open
   always @(posedge mclk) begin
      cyc <= mon ? cyc + 1 : 0;
      // Grant is registered: memory access pushes aside the request of the slot before
      reqLast <= fetchReq;
      nDelay <= !mon ? 0 : nDelay + int'(memGrant[0] === 1'b1 && reqLast === 1'b1);
      for (int v = 0; v < 2; v++) begin
         nStall[v] <= !mon ? 0 : nStall[v] + int'(decStall[v] === 1'b1);
         nMem[v] <= !mon ? 0 : nMem[v] + int'(memGrant[v] === 1'b1);
         nMul[v] <= !mon ? 0 : nMul[v] + int'(mulAccess[v] === 1'b1);
         nPtr[v] <= !mon ? 0 : nPtr[v] + int'(ptrWrite[v] === 1'b1);
         nReg[v] <= !mon ? 0 : nReg[v] + int'(regWrite[v] === 1'b1);
         nDisc[v] <= !mon ? 0 : nDisc[v] + int'(fetchDiscard[v] === 1'b1);
         nRed[v] <= !mon ? 0 : nRed[v] + int'(redirect[v] === 1'b1);
         nIll[v] <= !mon ? 0 : nIll[v] + int'(illegalOp[v] === 1'b1);
         if (!mon) lat[v] <= -1;
         else if (redirect[v] === 1'b1 && lat[v] < 0) lat[v] <= cyc;
         if (mon && regWrite[v] === 1'b1) lastDst[v] <= wbDst[v];
      end
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         bad_count++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : chk
   // One instruction, then a follower held long enough to cover every hold-off
   task automatic run(input logic [3:0] cls, creg, dst, fcls, fsrc);
      @(posedge mclk);
      #1;
      mon = 1'b1;
      decValid = 1'b1;
      decCls = cls;
      decCreg = creg;
      decDst = dst;
      decSrcA = 4'h1;
      @(posedge mclk);
      #1;
      decCls = fcls;
      decDst = GPR_NONE;
      decSrcA = fsrc;
      decSrcB = srcB;
      repeat (12) @(posedge mclk);
      #1;
      decValid = 1'b0;
      decSrcB = 4'h0;
      repeat (8) @(posedge mclk);
      #1;
      mon = 1'b0;
   endtask : run
   task automatic final_report;
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_branch;
      run(CLS_TRAP, 4'h0, GPR_NONE, CLS_PLAIN, 4'h2);
      chk(nRed[0] == 1 && nRed[1] == 1, "trap redirect count");
      chk(lat[1] - lat[0] == int'(EX_TRAP_DSP - EX_TRAP), "dsp trap length");
      chk(nDisc[0] == int'(DISCARD_TRAP) && nDisc[1] == int'(DISCARD_TRAP), "trap discards");
      tLat = lat[0];
      run(CLS_EXC_RETURN, 4'h0, GPR_NONE, CLS_PLAIN, 4'h2);
      chk(nRed[0] == 1 && lat[1] == lat[0], "return redirect");
      chk(tLat - lat[0] == int'(EX_TRAP - EX_RETURN), "trap vs return length");
      chk(nDisc[0] == int'(DISCARD_RETURN), "return discards");
   endtask : t_branch
   task automatic t_ctrl;
      run(CLS_CTRL_LOAD, 4'h1, 4'h3, CLS_PLAIN, 4'h5);
      chk(nStall[1] - nStall[0] == int'(HOLD_LOAD_DSP), "dsp load hold");
      chk(nReg[0] == 1 && lastDst[0] === 4'h3, "load write-back");
      chk(nMem[0] >= 1 && nDelay >= 1, "load bus arbitration");
      run(CLS_CTRL_LOAD, 4'h1, 4'h3, CLS_PLAIN, 4'h3);
      chk(nStall[0] >= 1, "dependent reader stall");
      // Same hazard seen through the second source port
      srcB = 4'h3;
      run(CLS_CTRL_LOAD, 4'h1, 4'h3, CLS_PLAIN, 4'h5);
      srcB = 4'h0;
      chk(nStall[0] >= 1, "second source reader stall");
      run(CLS_CTRL_STORE, 4'h1, GPR_NONE, CLS_PLAIN, 4'h5);
      chk(nStall[1] - nStall[0] == int'(HOLD_STORE_DSP), "dsp store hold");
      chk(nPtr[0] == 1 && nMem[0] >= 1, "store pointer write");
      run(CLS_BANK_STORE, 4'h1, GPR_NONE, CLS_PLAIN, 4'h5);
      chk(nStall[0] == int'(HOLD_BANK) && nStall[1] == int'(HOLD_BANK), "bank stall");
      chk(nMem[0] >= 1 && nDelay >= 1 && nPtr[0] == 1, "bank bus");
   endtask : t_ctrl
   task automatic t_dsp_only;
      for (int k = int'(CREG_BOUNDS); k <= int'(CREG_LOOP_LAST); k++) begin
         run(CLS_CTRL_LOAD, 4'(k), 4'h3, CLS_PLAIN, 4'h5);
         chk(nIll[0] == 1 && nIll[1] == 0, "dsp-only load");
         run(CLS_CTRL_STORE, 4'(k), GPR_NONE, CLS_PLAIN, 4'h5);
         chk(nIll[0] == 1 && nIll[1] == 0, "dsp-only store");
      end
   endtask : t_dsp_only
   task automatic t_mac;
      for (int k = int'(CLS_MAC_MOVE_IN); k <= int'(CLS_MAC_STORE); k++) begin
         run(4'(k), 4'h0, 4'h6, CLS_MUL_USER, 4'h5);
         chk(nMul[0] >= 1 && nMem[0] >= 1, "multiplier access");
         chk(nStall[0] >= 1, "multiplier user stall");
      end
      run(CLS_MAC_MOVE_OUT, 4'h0, 4'h6, CLS_PLAIN, 4'h6);
      chk(nReg[0] == 1 && lastDst[0] === 4'h6 && nStall[0] >= 1, "move out");
   endtask : t_mac
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_branch();
      t_ctrl();
      t_dsp_only();
      t_mac();
      slow = 1'b1;
      t_ctrl();
      chk(conflicts == 0 && starved == 0, "shared bus ownership");
      final_report();
   end
   // About 520 cycles are needed; a hang is cut well past that
   initial begin
      #400000;
      bad_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      final_report();
   end
endmodule : system_ctrl_pipeline_timing_tb_top
